//--- hdl/tbs_serdes.sv
// Ten-bit serdes parallel side: serializer, deserializer, comma alignment
`timescale 1ns/1ps
module tbs_serdes
    import tbs_pkg::*;
(
    input wire logic i_clock,                        // Controller clock
    input wire logic i_rst_n,                        // Sync reset, low
    input wire logic [tbs_pkg::TBS_CHAR_W-1:0] i_tx_char, // Tx char
    input wire logic i_tx_valid,                     // Tx char offered
    output logic o_tx_ready,                         // Tx queue has room
    input wire logic i_bit_clock,                    // Serial bit clock
    input wire logic i_loopback_enable,              // Loopback pin
    input wire logic i_comma_align_enable,           // Comma align pin
    input wire logic i_rx_serial,                    // Serial input
    output logic o_tx_p,                             // Serial out, true
    output logic o_tx_n,                             // Serial out, inverse
    output tbs_pkg::tbs_rx_t o_rx,                   // Rx char and flag
    output logic o_rx_clock,                         // Recovered clock
    output logic o_rx_clock_odd                      // Complement clock
);
    import tbs_pkg::*;

    // ****************************************************************
    // Controller domain: queue and word handoff
    // ****************************************************************
    logic fifo_ready, fifo_valid, pop_ready;
    logic [TBS_CHAR_W-1:0] fifo_data;
    logic req, next_req, ack_s1, ack_s2;
    logic ack, next_ack;
    logic [TBS_CHAR_W-1:0] word, next_word;
    logic tx_ready, next_tx_ready;

    tbs_fifo #(.WIDTH(TBS_CHAR_W), .DEPTH(TBS_FIFO_DEPTH)) u_fifo (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_in_valid(i_tx_valid),
        .i_in_data(i_tx_char),
        .o_in_ready(fifo_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(pop_ready)
    );

    // Only one word in flight; the link stalls the queue via the ack
    assign pop_ready = (req == ack_s2);

    always_comb begin
        next_req = req;
        next_word = word;
        next_tx_ready = fifo_ready;
        if (fifo_valid && pop_ready) begin
            next_req = ~req;
            next_word = fifo_data;
        end
    end

    // Word is held steady while the request toggle is outstanding
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            req <= 1'b0;
            word <= '0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            tx_ready <= 1'b0;
        end else begin
            req <= next_req;
            word <= next_word;
            ack_s1 <= ack;
            ack_s2 <= ack_s1;
            tx_ready <= next_tx_ready;
        end
    end
    assign o_tx_ready = tx_ready;

    // ****************************************************************
    // Link domain: synchronisers
    // ****************************************************************
    logic lr1, lr2, rq1, rq2, en1, en2, lb1, lb2, rx1, rx2;

    // Every link-side pin and the request toggle pass two flops before use; the word bus crosses unsynchronised
    always_ff @(posedge i_bit_clock) begin
        lr1 <= i_rst_n;
        lr2 <= lr1;
        rq1 <= req;
        rq2 <= rq1;
        en1 <= i_comma_align_enable;
        en2 <= en1;
        lb1 <= i_loopback_enable;
        lb2 <= lb1;
        rx1 <= i_rx_serial;
        rx2 <= rx1;
    end

    // ****************************************************************
    // Serializer
    // ****************************************************************
    logic idle_ph, next_idle_ph;
    logic [TBS_CHAR_W-1:0] tx_sh, next_tx_sh;
    logic [TBS_CNT_W-1:0] tx_cnt, next_tx_cnt;
    logic next_tx_p, next_tx_n;

    // Load at each character boundary; filler keeps the line busy
    always_comb begin
        next_ack = ack;
        next_idle_ph = idle_ph;
        next_tx_sh = {1'b0, tx_sh[TBS_CHAR_W-1:1]};
        next_tx_cnt = tx_cnt + TBS_CNT_STEP;
        if (tx_cnt == TBS_LAST_BIT) begin
            next_tx_cnt = TBS_FIRST_BIT;
            // Back-to-back commas would realign the receiver every slot,
            // so filler commas only go out on every other slot
            next_tx_sh = idle_ph ? TBS_IDLE_DATA : TBS_IDLE_CHAR;
            next_idle_ph = ~idle_ph;
            if (rq2 != ack) begin
                next_tx_sh = word;
                next_ack = ~ack;
            end
        end
        next_tx_p = lb2 ? 1'b1 : tx_sh[0];
        next_tx_n = lb2 ? 1'b0 : ~tx_sh[0];
    end

    always_ff @(posedge i_bit_clock) begin
        if (!lr2) begin
            ack <= 1'b0;
            idle_ph <= 1'b1;
            tx_sh <= TBS_IDLE_CHAR;
            tx_cnt <= TBS_FIRST_BIT;
            o_tx_p <= 1'b0;
            o_tx_n <= 1'b1;
        end else begin
            ack <= next_ack;
            idle_ph <= next_idle_ph;
            tx_sh <= next_tx_sh;
            tx_cnt <= next_tx_cnt;
            o_tx_p <= next_tx_p;
            o_tx_n <= next_tx_n;
        end
    end

    // ****************************************************************
    // Deserializer and comma alignment
    // ****************************************************************
    logic rx_in, comma_hit, rx_done;
    logic [TBS_CHAR_W-1:0] rx_sh, next_rx_sh;
    logic [TBS_CNT_W-1:0] rx_cnt, next_rx_cnt;
    logic rx_par, next_rx_par, pend, next_pend;
    tbs_rx_t next_rx;
    logic next_rx_clock, next_rx_clock_odd;

    // Loopback replaces the outside line with our own outgoing bit
    assign rx_in = lb2 ? tx_sh[0] : rx2;

    // Alignment after reset is arbitrary until a comma is seen
    always_comb begin
        next_rx_sh = {rx_in, rx_sh[TBS_CHAR_W-1:1]};
        comma_hit = (next_rx_sh[TBS_CHAR_W-1:3] == TBS_COMMA_PAT);
        rx_done = (rx_cnt == TBS_LAST_BIT);
        next_rx_cnt = rx_done ? TBS_FIRST_BIT : rx_cnt + TBS_CNT_STEP;
        next_rx_par = rx_done ? ~rx_par : rx_par;
        next_pend = rx_done ? 1'b0 : pend;
        next_rx = o_rx;
        next_rx_clock = o_rx_clock;
        next_rx_clock_odd = o_rx_clock_odd;
        if (rx_done) begin
            next_rx.data = next_rx_sh;
            next_rx.comma = pend && en2;
            next_rx_clock_odd = rx_par;
            next_rx_clock = ~rx_par;
        end
        // Boundary only ever moves while alignment is enabled
        if (comma_hit && en2) begin
            next_rx_cnt = TBS_AFTER_COMMA;
            next_rx_par = 1'b1;
            next_pend = 1'b1;
            // Park the odd clock low so the comma character raises it;
            // a comma on the wrong clock costs one short character
            next_rx_clock_odd = 1'b0;
            next_rx_clock = 1'b1;
        end
    end

    // Data and recovered clocks change together; the far end samples
    // on the clock edge, so it sees the previous character settled
    always_ff @(posedge i_bit_clock) begin
        if (!lr2) begin
            rx_sh <= '0;
            rx_cnt <= TBS_FIRST_BIT;
            rx_par <= 1'b0;
            pend <= 1'b0;
            o_rx <= '0;
            o_rx_clock <= 1'b0;
            o_rx_clock_odd <= 1'b1;
        end else begin
            rx_sh <= next_rx_sh;
            rx_cnt <= next_rx_cnt;
            rx_par <= next_rx_par;
            pend <= next_pend;
            o_rx <= next_rx;
            o_rx_clock <= next_rx_clock;
            o_rx_clock_odd <= next_rx_clock_odd;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    loop_hold_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2) lb2 |=> o_tx_p && !o_tx_n)
        else $error("loopback did not hold the serial pair");
    tx_order_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2)
        tx_cnt != TBS_LAST_BIT |=> tx_sh[8:0] == $past(tx_sh[9:1]))
        else $error("transmit bits not sent in ascending order");
    char_rate_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2)
        tx_cnt == TBS_FIRST_BIT |-> ##9 tx_cnt == TBS_LAST_BIT ##1
        tx_cnt == TBS_FIRST_BIT)
        else $error("transmit character period is not ten bits");
    rx_alternate_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2)
        rx_done && !(comma_hit && en2) |=> o_rx_clock != $past(o_rx_clock) &&
        o_rx_clock_odd == !o_rx_clock)
        else $error("recovered clocks did not alternate");
    rx_order_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2)
        rx_done |=> o_rx.data[9] == $past(rx_in) &&
        o_rx.data[8] == $past(rx_in, 2))
        else $error("latest receive bit not in top position");
    comma_gate_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2) $rose(o_rx.comma) |-> $past(en2))
        else $error("comma flag raised while disabled");
    comma_pat_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2)
        $rose(o_rx.comma) |-> o_rx.data[6:0] == TBS_COMMA_PAT)
        else $error("comma flag on a character without comma");
    comma_odd_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2)
        $rose(o_rx.comma) |-> $rose(o_rx_clock_odd))
        else $error("comma flag not with the odd clock");
    hold_align_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2)
        !en2 && !rx_done |=> rx_cnt == $past(rx_cnt) + TBS_CNT_STEP)
        else $error("boundary moved while alignment disabled");
    realign_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2)
        comma_hit && en2 |=> rx_cnt == TBS_AFTER_COMMA && rx_par)
        else $error("comma did not realign the boundary");
    loop_route_a: assert property (@(posedge i_bit_clock)
        disable iff (!lr2)
        lb2 && $past(lb2) |-> rx_sh[9] == $past(tx_sh[0]))
        else $error("loopback stream not in receive path");

    comma_flag_c: cover property (@(posedge i_bit_clock)
        disable iff (!lr2) $rose(o_rx.comma));
    realign_c: cover property (@(posedge i_bit_clock)
        disable iff (!lr2) comma_hit && en2 && rx_cnt != TBS_COMMA_BIT);
    loop_c: cover property (@(posedge i_bit_clock)
        disable iff (!lr2) lb2 && rx_done);
    tx_word_c: cover property (@(posedge i_bit_clock)
        disable iff (!lr2) tx_cnt == TBS_LAST_BIT && rq2 != ack);

endmodule : tbs_serdes

//--- hdl/tbs_pkg.sv
// Shared constants and carrier types for the ten-bit serdes block
package tbs_pkg;

    // ****************************************************************
    // Character format
    // ****************************************************************
    localparam int TBS_CHAR_W = 10;
    localparam int TBS_FIFO_DEPTH = 32;
    localparam int TBS_CNT_W = 4;
    // Bit index of the last bit of a character
    localparam logic [3:0] TBS_LAST_BIT = 4'h9;
    // Bit index that closes the seven comma bits when aligned
    localparam logic [3:0] TBS_COMMA_BIT = 4'h6;
    // Bit index following the comma's last bit
    localparam logic [3:0] TBS_AFTER_COMMA = 4'h7;
    localparam logic [3:0] TBS_FIRST_BIT = 4'h0;
    localparam logic [3:0] TBS_CNT_STEP = 4'h1;
    // Comma 0011111 with the first received bit in the lowest position
    localparam logic [6:0] TBS_COMMA_PAT = 7'h7C;
    // Filler sent when the controller has nothing queued (K28.5)
    localparam logic [9:0] TBS_IDLE_CHAR = 10'h17C;
    // Plain data filler between commas; no comma forms across either seam
    localparam logic [9:0] TBS_IDLE_DATA = 10'h255;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic comma;
        logic [TBS_CHAR_W-1:0] data;
    } tbs_rx_t;

endpackage : tbs_pkg

//--- hdl/tbs_fifo.sv
// Single-clock valid/ready FIFO holding transmit characters
`timescale 1ns/1ps
module tbs_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input wire logic i_clock,              // Clock
    input wire logic i_rst_n,              // Synchronous reset, low
    input wire logic i_in_valid,           // Write offer
    input wire logic [WIDTH-1:0] i_in_data, // Write data
    output logic o_in_ready,               // Room available
    output logic o_out_valid,              // Data available
    output logic [WIDTH-1:0] o_out_data,   // Head word
    input wire logic i_out_ready           // Reader takes head
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // Handshakes on both sides; a full FIFO refuses, an empty one idles
    always_comb begin
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    assign o_in_ready = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];

    // Pointers and storage
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // Never over- or underflows
    fifo_bound_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        count <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
    fifo_full_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (count == (AW+1)'(DEPTH)) && !pop |=> count == $past(count))
        else $error("fifo accepted while full");

endmodule : tbs_fifo

//--- tb/tbs_line_model.sv
// Far-end serial source feeding the receive pin, bit zero first
`timescale 1ns/1ps
module tbs_line_model (
    input wire logic i_bit_clock, // Serial bit clock
    output logic o_serial         // Serial line into the block
);
    logic [9:0] q[$];
    logic [9:0] sh;
    int cnt;

    // Queue one character for sending
    task automatic push(input logic [9:0] c);
        q.push_back(c);
    endtask : push

    initial begin
        o_serial = 1'b0;
        sh = 10'h155;
        cnt = 0;
    end

    // Idle line alternates, which can never form a comma by accident
    always @(posedge i_bit_clock) begin
        o_serial <= sh[0];
        if (cnt == 9) begin
            cnt <= 0;
            sh <= (q.size() > 0) ? q.pop_front() : 10'h155;
        end else begin
            cnt <= cnt + 1;
            sh <= sh >> 1;
        end
    end
endmodule : tbs_line_model

//--- tb/tbs_serdes_tb.sv
// Self-checking bench for the ten-bit serdes block
`timescale 1ns/1ps
module tbs_serdes_tb;
    import tbs_pkg::*;
    logic i_clock = 1'b0;
    logic i_bit_clock = 1'b0;
    logic i_rst_n;
    logic [TBS_CHAR_W-1:0] i_tx_char;
    logic i_tx_valid;
    logic i_loopback_enable;
    logic i_comma_align_enable;
    logic i_rx_serial;
    logic o_tx_ready, o_tx_p, o_tx_n, o_rx_clock, o_rx_clock_odd;
    tbs_rx_t o_rx;
    logic last_clk = 1'b0;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;

    // ************************************************************
    // Clocks, instances, timeout
    // ************************************************************
    always #12.5 i_clock = ~i_clock;
    // Offset start keeps the link clock out of phase with the other
    initial #3 forever #7.5 i_bit_clock = ~i_bit_clock;

    tbs_serdes u_tbs_serdes (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_tx_char(i_tx_char), .i_tx_valid(i_tx_valid),
        .o_tx_ready(o_tx_ready), .i_bit_clock(i_bit_clock),
        .i_loopback_enable(i_loopback_enable),
        .i_comma_align_enable(i_comma_align_enable),
        .i_rx_serial(i_rx_serial), .o_tx_p(o_tx_p), .o_tx_n(o_tx_n),
        .o_rx(o_rx), .o_rx_clock(o_rx_clock),
        .o_rx_clock_odd(o_rx_clock_odd));
    tbs_line_model u_tbs_line_model (.i_bit_clock(i_bit_clock),
        .o_serial(i_rx_serial));

    // A hang counts as a mismatch and goes to the closing report
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            wrap_up();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // Each toggle of the recovered clock marks one new character
    task automatic next_char(output tbs_rx_t c, output logic odd);
        int n;
        n = 0;
        do begin
            @(posedge i_bit_clock);
            #1;
            n++;
        end while (o_rx_clock === last_clk && n < 30);
        if (n >= 30) check("rx char timeout", 1'b0, 1'b1);
        last_clk = o_rx_clock;
        c = o_rx;
        odd = o_rx_clock_odd;
    endtask : next_char

    // Skips characters until the expected one shows, bounded by lim
    task automatic find_char(input logic [9:0] d, input logic k,
                             input int lim);
        tbs_rx_t c;
        logic odd;
        last_clk = o_rx_clock;
        for (int i = 0; i < lim; i++) begin
            next_char(c, odd);
            if (c.data === d) break;
        end
        check("rx data", c.data, d);
        check("rx comma flag", c.comma, k);
        if (k) check("comma on odd clock", odd, 1'b1);
    endtask : find_char

    task automatic send_tx(input logic [9:0] c);
        int n;
        n = 0;
        @(posedge i_clock);
        while (o_tx_ready !== 1'b1 && n < 100) begin
            @(posedge i_clock);
            n++;
        end
        i_tx_char <= c;
        i_tx_valid <= 1'b1;
        @(posedge i_clock);
        i_tx_valid <= 1'b0;
    endtask : send_tx

    task automatic set_pins(input logic lb, input logic ce);
        @(posedge i_clock);
        i_loopback_enable <= lb;
        i_comma_align_enable <= ce;
        repeat (4) @(posedge i_bit_clock);
    endtask : set_pins

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic sc_reset();
        i_rst_n <= 1'b0;
        i_tx_char <= 10'h000;
        i_tx_valid <= 1'b0;
        i_loopback_enable <= 1'b0;
        i_comma_align_enable <= 1'b0;
        repeat (5) @(posedge i_clock);
        #1;
        check("ready in reset", o_tx_ready, 1'b0);
        check("tx pair in reset", {o_tx_p, o_tx_n}, 2'h1);
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        #1;
        check("ready after reset", o_tx_ready, 1'b1);
        repeat (4) @(posedge i_bit_clock);
    endtask : sc_reset

    // Comma aligns, then the next character arrives on the even clock
    task automatic sc_external();
        tbs_rx_t c;
        logic odd;
        set_pins(1'b0, 1'b1);
        u_tbs_line_model.push(10'h17C);
        u_tbs_line_model.push(10'h2A5);
        find_char(10'h17C, 1'b1, 12);
        next_char(c, odd);
        check("char after comma", c.data, 10'h2A5);
        check("flag after comma", c.comma, 1'b0);
        check("alternate clock", odd, 1'b0);
    endtask : sc_external

    // Disabled: a shifted comma neither flags nor moves the boundary
    task automatic sc_disabled();
        tbs_rx_t c;
        logic odd;
        set_pins(1'b0, 1'b0);
        u_tbs_line_model.push(10'h3E0);
        u_tbs_line_model.push(10'h2A5);
        u_tbs_line_model.push(10'h17C);
        find_char(10'h3E0, 1'b0, 12);
        next_char(c, odd);
        check("frozen alignment", c.data, 10'h2A5);
        find_char(10'h17C, 1'b0, 4);
    endtask : sc_disabled

    // Enabled: comma three bits late shifts the word boundary
    task automatic sc_realign();
        set_pins(1'b0, 1'b1);
        u_tbs_line_model.push(10'h3E0);
        u_tbs_line_model.push(10'h2A5);
        find_char(10'h2FC, 1'b1, 12);
    endtask : sc_realign

    task automatic sc_loopback();
        int bad;
        bad = 0;
        set_pins(1'b1, 1'b1);
        repeat (20) begin
            @(posedge i_bit_clock);
            #1;
            if (o_tx_p !== 1'b1 || o_tx_n !== 1'b0) bad++;
        end
        check("loopback pair level", bad[7:0], 8'h00);
        find_char(10'h17C, 1'b1, 12);
        send_tx(10'h1B3);
        find_char(10'h1B3, 1'b0, 20);
    endtask : sc_loopback

    // Fill the queue until it refuses, then let it drain to filler
    task automatic sc_fill();
        int n;
        n = 0;
        @(posedge i_clock);
        i_tx_char <= 10'h2A5;
        i_tx_valid <= 1'b1;
        while (o_tx_ready === 1'b1 && n < 200) begin
            @(posedge i_clock);
            n++;
        end
        i_tx_valid <= 1'b0;
        check("queue refused", (n >= 31 && n < 200), 1'b1);
        n = 0;
        while (o_tx_ready !== 1'b1 && n < 300) begin
            @(posedge i_clock);
            n++;
        end
        check("queue drains", o_tx_ready, 1'b1);
        find_char(10'h17C, 1'b1, 60);
    endtask : sc_fill

    initial begin
        sc_reset();
        sc_external();
        sc_disabled();
        sc_realign();
        sc_loopback();
        sc_fill();
        wrap_up();
    end
endmodule : tbs_serdes_tb
